// File: abs_ctrl.sv
// Scan test controller: runs a converter limit check through the boundary-scan chain.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "abs_regs.svh"
module abs_ctrl (
    input wire logic ref_clk, // System clock, 25 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    output logic tck, // Test clock to the device.
    output logic tms, // Test mode select.
    output logic tdi, // Test data into the device.
    input wire logic tdo // Test data from the device.
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Builds the whole chain for one step; every port-pin cell stays zero, which keeps
    // all pins inputs with pull-ups off, including the one on the selected channel.
    function automatic abs_pkg::abs_vec_t build_vec(input logic [3:0] step,
                                                    input logic [7:0] chan,
                                                    input logic [1:0] neg,
                                                    input logic [9:0] lo,
                                                    input logic [9:0] hi);
        abs_pkg::abs_vec_t v;
        logic last;
        v = '0;
        last = (step == 4'hc);
        v[`ABS_BIT_PWR] = ~last;
        v[`ABS_BIT_GAINPWR] = 1'b0;
        v[`ABS_BIT_SETTLE] = 1'b0;
        v[`ABS_BIT_SWITCHCAP_TEST_ENABLE] = 1'b0;
        v[`ABS_BIT_PASS] = 1'b1;
        v[`ABS_BIT_VREF] = 1'b0;
        v[`ABS_BIT_BYPASS] = 1'b1;
        v[`ABS_BIT_CHAN_HI:`ABS_BIT_CHAN_LO] = last ? 8'h01 : chan;
        v[`ABS_BIT_GNDNEG] = ~last & (neg == 2'h1);
        v[`ABS_BIT_BGNEG] = ~last & (neg == 2'h2);
        v[`ABS_BIT_HOLD] = !(step == 4'h2 || step == 4'h7);
        v[`ABS_BIT_COMPARATOR_PRECHARGE_N] = !(step == 4'h5 || step == 4'ha);
        case (step)
            4'h4, 4'h5: v[`ABS_BIT_DAC_HI:`ABS_BIT_DAC_LO] = lo;
            4'h9, 4'ha: v[`ABS_BIT_DAC_HI:`ABS_BIT_DAC_LO] = hi;
            default: v[`ABS_BIT_DAC_HI:`ABS_BIT_DAC_LO] = `ABS_DAC_MID;
        endcase
        return v;
    endfunction : build_vec

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [31:0] cfg_q, cfg_d, chan_q, chan_d, limit_q, limit_d;
    logic start;
    logic [31:0] status;

    // ****************************************************************
    // Sequencer state
    // ****************************************************************
    abs_pkg::abs_seq_e st_q, st_d;
    logic [3:0] step_q, step_d;
    logic [3:0] wait_q, wait_d;
    logic req_q, req_d, ir_q, ir_d;
    logic [7:0] len_q, len_d;
    abs_pkg::abs_vec_t wvec_q, wvec_d;
    logic done_q, done_d, lofail_q, lofail_d, hifail_q, hifail_d;

    abs_scan_if sc ();

    always_comb begin
        status = {20'h0, step_q, 3'h0, hifail_q, lofail_q,
                  done_q & ~lofail_q & ~hifail_q, done_q, st_q != abs_pkg::M_IDLE};
        awready_d = awready_q;
        wready_d = wready_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        cfg_d = cfg_q;
        chan_d = chan_q;
        limit_d = limit_q;
        start = 1'b0;
        if (s_axi_awvalid && awready_q) begin
            awaddr_d = s_axi_awaddr;
            awready_d = 1'b0;
        end
        if (s_axi_wvalid && wready_q) begin
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
            wready_d = 1'b0;
        end
        if (!awready_q && !wready_q && !bvalid_q) begin
            bvalid_d = 1'b1;
            bresp_d = 2'h0;
            case (awaddr_q)
                `ABS_OFS_CTRL: start = wstrb_q[0] & wdata_q[0];
                `ABS_OFS_CFG: cfg_d = merge(cfg_q, wdata_q, wstrb_q) & 32'h0000_03ff;
                `ABS_OFS_CHAN: chan_d = merge(chan_q, wdata_q, wstrb_q) & 32'h0000_00ff;
                `ABS_OFS_LIMIT: limit_d = merge(limit_q, wdata_q, wstrb_q) & 32'h03ff_03ff;
                `ABS_OFS_STATUS: bresp_d = 2'h0;
                default: bresp_d = 2'h2;
            endcase
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = 2'h0;
            case (s_axi_araddr)
                `ABS_OFS_CTRL: rdata_d = 32'h0;
                `ABS_OFS_CFG: rdata_d = cfg_q;
                `ABS_OFS_CHAN: rdata_d = chan_q;
                `ABS_OFS_LIMIT: rdata_d = limit_q;
                `ABS_OFS_STATUS: rdata_d = status;
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = 2'h2;
                end
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
            cfg_q <= `ABS_CFG_RST;
            chan_q <= {24'h0, `ABS_CHAN_RST};
            limit_q <= {6'h0, `ABS_LIMIT_HI_RST, 6'h0, `ABS_LIMIT_LO_RST};
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            cfg_q <= cfg_d;
            chan_q <= chan_d;
            limit_q <= limit_d;
        end
    end

    // ****************************************************************
    // Check sequence
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        step_d = step_q;
        wait_d = wait_q;
        req_d = 1'b0;
        ir_d = ir_q;
        len_d = len_q;
        wvec_d = wvec_q;
        done_d = done_q;
        lofail_d = lofail_q;
        hifail_d = hifail_q;
        case (st_q)
            abs_pkg::M_IDLE: begin
                if (start) begin
                    step_d = 4'h1;
                    done_d = 1'b0;
                    lofail_d = 1'b0;
                    hifail_d = 1'b0;
                    st_d = abs_pkg::M_IR_REQ;
                end
            end
            abs_pkg::M_IR_REQ: begin
                if (!sc.busy) begin
                    req_d = 1'b1;
                    ir_d = 1'b1;
                    len_d = 8'(`ABS_IR_LEN);
                    wvec_d = '0;
                    wvec_d[3:0] = (step_q == 4'h1) ? cfg_q[3:0] : cfg_q[7:4];
                    st_d = abs_pkg::M_IR_WAIT;
                end
            end
            abs_pkg::M_IR_WAIT: begin
                if (sc.done) begin
                    st_d = abs_pkg::M_DR_REQ;
                end
            end
            abs_pkg::M_DR_REQ: begin
                if (!sc.busy) begin
                    req_d = 1'b1;
                    ir_d = 1'b0;
                    len_d = 8'(`ABS_CHAIN_LEN);
                    wvec_d = build_vec(step_q, chan_q[7:0], cfg_q[9:8],
                                       limit_q[9:0], limit_q[25:16]);
                    st_d = abs_pkg::M_DR_WAIT;
                end
            end
            abs_pkg::M_DR_WAIT: begin
                if (sc.done) begin
                    // The comparator result set up by step 5 or 10 comes out while the
                    // following step is shifted in.
                    if (step_q == 4'h6 && sc.rvec[`ABS_BIT_COMP]) begin
                        lofail_d = 1'b1;
                    end
                    if (step_q == 4'hb && !sc.rvec[`ABS_BIT_COMP]) begin
                        hifail_d = 1'b1;
                    end
                    step_d = step_q + 4'h1;
                    wait_d = 4'h0;
                    if (step_q == 4'hc) begin
                        done_d = 1'b1;
                        st_d = abs_pkg::M_IDLE;
                    end else if (step_q == 4'h1) begin
                        st_d = abs_pkg::M_IR_REQ;
                    end else if (step_q == 4'h2) begin
                        st_d = abs_pkg::M_SETTLE;
                    end else begin
                        st_d = abs_pkg::M_DR_REQ;
                    end
                end
            end
            abs_pkg::M_SETTLE: begin
                // The converter was just powered by EXTEST; give it time before step 3.
                wait_d = wait_q + 4'h1;
                if (wait_q == 4'(`ABS_ENABLE_WAIT_CYC - 1)) begin
                    st_d = abs_pkg::M_DR_REQ;
                end
            end
            default: st_d = abs_pkg::M_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q <= abs_pkg::M_IDLE;
            step_q <= 4'h0;
            wait_q <= 4'h0;
            req_q <= 1'b0;
            ir_q <= 1'b0;
            len_q <= 8'h00;
            wvec_q <= '0;
            done_q <= 1'b0;
            lofail_q <= 1'b0;
            hifail_q <= 1'b0;
        end else begin
            st_q <= st_d;
            step_q <= step_d;
            wait_q <= wait_d;
            req_q <= req_d;
            ir_q <= ir_d;
            len_q <= len_d;
            wvec_q <= wvec_d;
            done_q <= done_d;
            lofail_q <= lofail_d;
            hifail_q <= hifail_d;
        end
    end

    assign sc.req = req_q;
    assign sc.is_ir = ir_q;
    assign sc.len = len_q;
    assign sc.wvec = wvec_q;

    // A fixed TCK of ref_clk/8 keeps the ten held steps short; the hold time of the
    // converter sets the floor on this rate.
    abs_tap u_tap (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .sc(sc),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .tdo(tdo)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule : abs_ctrl
`default_nettype wire

// File: abs_ctrl_properties.sv
// Port checker for the scan test controller.
`timescale 1ns/1ps
`default_nettype none
module abs_ctrl_properties (
    input wire logic ref_clk, // Clock.
    input wire logic sys_rst, // Reset.
    input wire logic s_axi_awvalid, // Aw valid.
    input wire logic s_axi_awready, // Aw ready.
    input wire logic s_axi_wvalid, // W valid.
    input wire logic s_axi_wready, // W ready.
    input wire logic s_axi_bvalid, // B valid.
    input wire logic s_axi_bready, // B ready.
    input wire logic s_axi_arvalid, // Ar valid.
    input wire logic s_axi_arready, // Ar ready.
    input wire logic s_axi_rvalid, // R valid.
    input wire logic s_axi_rready, // R ready.
    input wire logic tck, // Test clock.
    input wire logic tms // Mode select.
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_tck_period: assert property ($rose(tck) |-> ##8 $rose(tck)) else $error("tck period");
    a_tck_half: assert property ($rose(tck) |-> tck[*4] ##1 !tck) else $error("tck high");
    a_tms_steady: assert property (tck |-> $stable(tms)) else $error("tms moved");
    a_b_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("no bvalid");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b drop");
    a_aw_closed: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("aw");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r drop");
endmodule : abs_ctrl_properties
bind abs_ctrl abs_ctrl_properties i_props (.ref_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .tck, .tms);
`default_nettype wire

// File: abs_dev_model.sv
// Device model: TAP, boundary chain and comparator.
`timescale 1ns/1ps
`default_nettype none
module abs_dev_model #(
    parameter logic [3:0] EXT_OP = 4'h0
) (
    input wire logic tck, // Test clock.
    input wire logic tms, // Mode select.
    input wire logic tdi, // Data in.
    output logic tdo, // Data out.
    input wire logic [9:0] vin_code, // Applied voltage.
    output logic bad_q // Forbidden setting seen.
);
    localparam logic [63:0] NXT1 = 64'h2fefcc0287855920;
    localparam logic [63:0] NXT0 = 64'h1bddbba146644311;
    logic [3:0] st_q = 4'h0;
    logic [3:0] ir_q = 4'hf;
    logic [3:0] irs_q = 4'h0;
    logic [204:0] sh_q = '0;
    logic comp_q = 1'b0;
    logic pwr_q = 1'b0;
    realtime on_t = 0.0;
    initial bad_q = 1'b0;
    initial tdo = 1'b0;
    always @(posedge tck) begin
        st_q <= tms ? NXT1[st_q*4+:4] : NXT0[st_q*4+:4];
        if (st_q == 4'h0) ir_q <= 4'hf;
        if (st_q == 4'h3) sh_q[200] <= comp_q;
        if (st_q == 4'h4) sh_q <= {tdi, sh_q[204:1]};
        if (st_q == 4'hb) irs_q <= {tdi, irs_q[3:1]};
        if (st_q == 4'hf) ir_q <= irs_q;
        if (st_q == 4'h8 && ir_q == EXT_OP) begin
            // Off-midpoint sampling or two negative paths would spoil the result.
            if ((!sh_q[178] && sh_q[192:183] != 10'h200) || (sh_q[179] && sh_q[195]) || sh_q[193]) bad_q <= 1'b1;
            // A freshly powered converter is still busy with its dummy conversion.
            if (!sh_q[164] && (!pwr_q || $realtime - on_t < 200.0)) bad_q <= 1'b1;
            if (sh_q[194] && !pwr_q) on_t <= $realtime;
            pwr_q <= sh_q[194];
            if (sh_q[194] && sh_q[165] && !sh_q[161] && sh_q[178] && !sh_q[164]) comp_q <= sh_q[192:183] > vin_code;
        end
    end
    // Outside a shift the line toggles so stale data cannot pass as valid.
    always @(negedge tck) tdo <= st_q == 4'h4 ? sh_q[0] : st_q == 4'hb ? irs_q[0] : ~tdo;
endmodule : abs_dev_model
`default_nettype wire

// File: abs_pkg.sv
// Types shared by the scan test controller modules.
`default_nettype none
`include "abs_regs.svh"
package abs_pkg;
    typedef logic [`ABS_CHAIN_LEN-1:0] abs_vec_t;

    typedef enum logic [4:0] {
        T_RST = 5'h01,
        T_IDLE = 5'h02,
        T_PRE = 5'h04,
        T_SHIFT = 5'h08,
        T_POST = 5'h10
    } abs_tap_e;

    typedef enum logic [5:0] {
        M_IDLE = 6'h01,
        M_IR_REQ = 6'h02,
        M_IR_WAIT = 6'h04,
        M_DR_REQ = 6'h08,
        M_DR_WAIT = 6'h10,
        M_SETTLE = 6'h20
    } abs_seq_e;
endpackage : abs_pkg
`default_nettype wire

// File: abs_regs.svh
// Offsets, field positions, reset values and timing counts of the scan test controller.
`ifndef ABS_REGS_SVH
`define ABS_REGS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define ABS_CLK_PERIOD_NS 40
`define ABS_ENABLE_WAIT_NS 200
`define ABS_ENABLE_WAIT_CYC ((`ABS_ENABLE_WAIT_NS + `ABS_CLK_PERIOD_NS - 1) / `ABS_CLK_PERIOD_NS)
`define ABS_TCK_HALF_CYC 4
`define ABS_TAP_RESET_TCKS 5

// ****************************************************************
// Boundary-scan chain layout
// ****************************************************************
`define ABS_CHAIN_LEN 205
`define ABS_IR_LEN 4
`define ABS_BIT_COMP 200
`define ABS_BIT_ACLK 198
`define ABS_BIT_ACTEN 197
`define ABS_BIT_BGNEG 195
`define ABS_BIT_PWR 194
`define ABS_BIT_GAINPWR 193
`define ABS_BIT_DAC_HI 192
`define ABS_BIT_DAC_LO 183
`define ABS_BIT_BYPASS 182
`define ABS_BIT_G10 181
`define ABS_BIT_G20 180
`define ABS_BIT_GNDNEG 179
`define ABS_BIT_HOLD 178
`define ABS_BIT_IREF 177
`define ABS_BIT_CHAN_HI 176
`define ABS_BIT_CHAN_LO 169
`define ABS_BIT_NEG_HI 168
`define ABS_BIT_NEG_LO 166
`define ABS_BIT_PASS 165
`define ABS_BIT_COMPARATOR_PRECHARGE_N 164
`define ABS_BIT_SWITCHCAP_TEST_ENABLE 163
`define ABS_BIT_SETTLE 162
`define ABS_BIT_VREF 161
`define ABS_DAC_MID 10'h200

// TMS walks from Run-Test/Idle to Shift, first bit in bit 0.
`define ABS_PRE_DR 4'h1
`define ABS_PRE_DR_LEN 3'h3
`define ABS_PRE_IR 4'h3
`define ABS_PRE_IR_LEN 3'h4

// ****************************************************************
// Register map
// ****************************************************************
`define ABS_OFS_CTRL 8'h00
`define ABS_OFS_CFG 8'h04
`define ABS_OFS_CHAN 8'h08
`define ABS_OFS_LIMIT 8'h0c
`define ABS_OFS_STATUS 8'h10
`define ABS_CFG_RST 32'h0000_0002
`define ABS_CHAN_RST 8'h08
`define ABS_LIMIT_LO_RST 10'h123
`define ABS_LIMIT_HI_RST 10'h143

`endif

// File: abs_scan_if.sv
// Request and answer signals between the sequencer and the TAP driver.
`timescale 1ns/1ps
`default_nettype none
interface abs_scan_if;
    logic req;
    logic is_ir;
    logic [7:0] len;
    abs_pkg::abs_vec_t wvec;
    logic busy;
    logic done;
    abs_pkg::abs_vec_t rvec;

    modport seq (output req, output is_ir, output len, output wvec,
                 input busy, input done, input rvec);
    modport tap (input req, input is_ir, input len, input wvec,
                 output busy, output done, output rvec);
endinterface : abs_scan_if
`default_nettype wire

// File: abs_tap.sv
// TAP driver: makes TCK by division and walks the TAP through IR or DR scans.
`timescale 1ns/1ps
`default_nettype none
`include "abs_regs.svh"
module abs_tap (
    input wire logic ref_clk, // System clock.
    input wire logic sys_rst, // Synchronous reset, active high.
    abs_scan_if.tap sc, // Scan requests from the sequencer.
    output logic tck, // Test clock to the device.
    output logic tms, // Test mode select.
    output logic tdi, // Test data into the device.
    input wire logic tdo // Test data from the device.
);
    abs_pkg::abs_tap_e st_q, st_d;
    logic [1:0] div_q, div_d;
    logic tck_q, tck_d, tms_q, tms_d, tdi_q, tdi_d;
    logic tdo_m_q, tdo_s_q;
    logic pend_q, pend_d, ir_q, ir_d, done_q, done_d;
    logic [7:0] len_q, len_d, cnt_q, cnt_d;
    abs_pkg::abs_vec_t sr_q, sr_d, rvec_q, rvec_d;
    logic tick, rise, fall;
    logic [3:0] pre_pat;
    logic [2:0] pre_len;

    always_comb begin
        tick = (div_q == 2'(`ABS_TCK_HALF_CYC - 1));
        rise = tick & ~tck_q;
        fall = tick & tck_q;
        pre_pat = ir_q ? `ABS_PRE_IR : `ABS_PRE_DR;
        pre_len = ir_q ? `ABS_PRE_IR_LEN : `ABS_PRE_DR_LEN;
        st_d = st_q;
        div_d = tick ? 2'h0 : div_q + 2'h1;
        tck_d = tick ? ~tck_q : tck_q;
        tms_d = tms_q;
        tdi_d = tdi_q;
        pend_d = pend_q | sc.req;
        ir_d = ir_q;
        len_d = len_q;
        cnt_d = cnt_q;
        sr_d = sr_q;
        rvec_d = rvec_q;
        done_d = 1'b0;
        if (sc.req && st_q == abs_pkg::T_IDLE && !pend_q) begin
            ir_d = sc.is_ir;
            len_d = sc.len;
            sr_d = sc.wvec;
        end
        // Drive TMS and TDI after the falling edge; the device samples at the rising one.
        if (fall) begin
            case (st_q)
                abs_pkg::T_RST: tms_d = (cnt_q < 8'(`ABS_TAP_RESET_TCKS));
                abs_pkg::T_IDLE: tms_d = 1'b0;
                abs_pkg::T_PRE: tms_d = pre_pat[cnt_q[1:0]];
                abs_pkg::T_SHIFT: begin
                    tms_d = (cnt_q == len_q - 8'h01);
                    tdi_d = sr_q[0];
                end
                abs_pkg::T_POST: tms_d = (cnt_q == 8'h00);
                default: tms_d = 1'b1;
            endcase
        end
        if (rise) begin
            cnt_d = cnt_q + 8'h01;
            case (st_q)
                abs_pkg::T_RST: begin
                    if (cnt_q == 8'(`ABS_TAP_RESET_TCKS)) begin
                        st_d = abs_pkg::T_IDLE;
                        cnt_d = 8'h00;
                    end
                end
                abs_pkg::T_IDLE: begin
                    cnt_d = 8'h00;
                    if (pend_q) begin
                        st_d = abs_pkg::T_PRE;
                    end
                end
                abs_pkg::T_PRE: begin
                    if (cnt_q == {5'h00, pre_len} - 8'h01) begin
                        st_d = abs_pkg::T_SHIFT;
                        cnt_d = 8'h00;
                    end
                end
                abs_pkg::T_SHIFT: begin
                    sr_d = {tdo_s_q, sr_q[`ABS_CHAIN_LEN-1:1]};
                    if (cnt_q == len_q - 8'h01) begin
                        st_d = abs_pkg::T_POST;
                        cnt_d = 8'h00;
                    end
                end
                abs_pkg::T_POST: begin
                    if (cnt_q == 8'h01) begin
                        st_d = abs_pkg::T_IDLE;
                        cnt_d = 8'h00;
                        pend_d = 1'b0;
                        done_d = 1'b1;
                        rvec_d = sr_q;
                    end
                end
                default: st_d = abs_pkg::T_RST;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        tdo_m_q <= tdo;
        tdo_s_q <= tdo_m_q;
        if (sys_rst) begin
            st_q <= abs_pkg::T_RST;
            div_q <= 2'h0;
            tck_q <= 1'b0;
            tms_q <= 1'b1;
            tdi_q <= 1'b0;
            pend_q <= 1'b0;
            ir_q <= 1'b0;
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            sr_q <= '0;
            rvec_q <= '0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            tck_q <= tck_d;
            tms_q <= tms_d;
            tdi_q <= tdi_d;
            pend_q <= pend_d;
            ir_q <= ir_d;
            len_q <= len_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            rvec_q <= rvec_d;
            done_q <= done_d;
        end
    end

    assign tck = tck_q;
    assign tms = tms_q;
    assign tdi = tdi_q;
    assign sc.busy = pend_q | (st_q != abs_pkg::T_IDLE);
    assign sc.done = done_q;
    assign sc.rvec = rvec_q;
endmodule : abs_tap
`default_nettype wire

// File: tb_abs_ctrl.sv
// Bench for the scan test controller.
`timescale 1ns/1ps
`default_nettype none
module tb_abs_ctrl;
    localparam logic [9:0] VINS [3] = '{10'h133, 10'h100, 10'h150};
    localparam logic [31:0] EXPS [3] = '{32'h06, 32'h0a, 32'h12};
    logic ref_clk = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tck, tms, tdi, tdo, dev_bad;
    logic [9:0] vin_code = 10'h133;
    int fail_count = 0, checks = 0, cyc = 0;
    always #20 ref_clk = ~ref_clk;
    abs_ctrl i_dut (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tck, .tms, .tdi, .tdo);
    abs_dev_model i_dev (.tck, .tms, .tdi, .tdo, .vin_code, .bad_q(dev_bad));
    task automatic final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge ref_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd_q = s_axi_rdata;
        if (e !== 32'hffff_ffff) chk("rdata", rd_q, e);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
    endtask : rc
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rc(8'h04, 32'h002, 2'b00);
        rc(8'h08, 32'h008, 2'b00);
        rc(8'h0c, 32'h0143_0123, 2'b00);
        rc(8'h14, 32'h0, 2'b10);
        wr(8'h14, 32'hffff_ffff, 2'b10);
        wr(8'h04, 32'h0000_0102, 2'b00);
        for (int k = 0; k < 3; k++) begin
            vin_code <= VINS[k];
            wr(8'h00, 32'h1, 2'b00);
            do rc(8'h10, 32'hffff_ffff, 2'b00); while (rd_q[1] !== 1'b1);
            chk("status", rd_q & 32'h1f, EXPS[k]);
        end
        chk("contention", {31'h0, dev_bad}, 32'h0);
        final_report();
    end
endmodule : tb_abs_ctrl
`default_nettype wire
